// ---- rtl/gsdl_defines.svh ----
// Constants for the gateway switch decode and status lamp block
`ifndef GSDL_DEFINES_SVH
`define GSDL_DEFINES_SVH

// ==========================================
// Timing
`define GSDL_CLK_HZ 100000000
`define GSDL_FLASH_HALF_MS 200
`define GSDL_USER_HALF_MS 1000
`define GSDL_WARN_TIME_S 60
`define GSDL_SETTLE_CYC 4'h4

// ==========================================
// Register byte addresses
`define GSDL_A_SEL 6'h00
`define GSDL_A_NODE 6'h04
`define GSDL_A_NVID 6'h08
`define GSDL_A_ERR 6'h0c
`define GSDL_A_WTIME 6'h10
`define GSDL_A_SCRIPT 6'h14
`define GSDL_A_CMD 6'h18
`define GSDL_A_LINK 6'h1c
`define GSDL_A_ISTAT 6'h20
`define GSDL_A_IMASK 6'h24

// ==========================================
// Selector codes and reset values
`define GSDL_CODE_UPDATE 8'hdd
`define GSDL_CODE_TEST 8'hee
`define GSDL_CODE_CONFIG 8'hff
`define GSDL_NVID_RST 8'h01
`define GSDL_WTIME_RST 8'h0a
`define GSDL_ERR_WARN_MIN 4'h6

// ==========================================
// Field positions
`define GSDL_ERR_USER 4
`define GSDL_SCR_ST_EN 0
`define GSDL_SCR_ST_LSB 1
`define GSDL_SCR_ER_EN 4
`define GSDL_SCR_ER_LSB 5
`define GSDL_LINK_HALT 0
`define GSDL_LINK_PC 1
`define GSDL_CMD_DONE 0
`define GSDL_IRQ_MODE 0
`define GSDL_IRQ_ERR 1
`define GSDL_IRQ_EXPIRE 2
`define GSDL_IRQ_SEL 3
`define GSDL_IRQ_W 4

`endif

// ---- rtl/gsdl_pkg.sv ----
// Types shared by the switch decode and lamp logic
`default_nettype none
package gsdl_pkg;
   // Bicolour lamp drive
   typedef struct packed {
      logic red;
      logic green;
   } gsdl_lamp_t;

   // Two rotary selector nibbles, high first
   typedef struct packed {
      logic [3:0] hi;
      logic [3:0] lo;
   } gsdl_sel_t;

   // Operating mode, Gray coded
   typedef enum logic [1:0] {
      GSDL_NORMAL = 2'h0,
      GSDL_UPDATE = 2'h1,
      GSDL_TEST = 2'h3,
      GSDL_CONFIG = 2'h2
   } gsdl_mode_t;

   // Script choices for the state lamp
   typedef enum logic [2:0] {
      GSDL_SC_OFF = 3'h0,
      GSDL_SC_GREEN = 3'h1,
      GSDL_SC_GREEN_FL = 3'h2,
      GSDL_SC_GR_FL = 3'h3,
      GSDL_SC_RED = 3'h4,
      GSDL_SC_RED_FL = 3'h5
   } gsdl_script_st_t;
endpackage : gsdl_pkg
`default_nettype wire

// ---- rtl/gsdl_blink.sv ----
// Free-running flash phase generator with half-period tick
`default_nettype none
module gsdl_blink #(
   parameter int P_HALF_CYC = 20000000
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   output logic o_phase,
   output logic o_tick
);
   // ==========================================
   // Elaboration check
   generate
      if (P_HALF_CYC < 1) begin : g_bad
         $error("gsdl_blink: half period below one cycle");
      end
   endgenerate

   logic [31:0] cnt_r; // Cycles into the half period

   // Half-period counter; tick marks each phase flip
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= 32'h0;
         o_phase <= 1'b0;
         o_tick <= 1'b0;
      end else if (cnt_r == 32'(P_HALF_CYC - 1)) begin
         cnt_r <= 32'h0;
         o_phase <= ~o_phase;
         o_tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h1;
         o_tick <= 1'b0;
      end
   end
endmodule : gsdl_blink
`default_nettype wire

// ---- rtl/gsdl_top.sv ----
// Selector decode, node identity choice and front lamp drive
//
// Behaviour
// - Config/error: power lamp flashes red; test: green/red
// - Halted base, PC link: power lamp bright red
// - General error: state lamp steady red, number shown
// - Config/test: state lamp flashes red unless scripted or an error is shown
// - Error number shown binary on four lamps
// - Script may override state and error lamps
// - Selector byte: high nibble first, software readable
// - Sample selectors at power-up and after commands
// - EE selects test, FF selects config
// - Test/config mode held until reboot
// - DD selects extension firmware-update mode
// - Node identity and bit rate from DIP field
// - DIP node zero: use stored node identity
// - Stored identity may exceed DIP range
// - Stored identity resets to one
// - Warnings six to fifteen clear after a minute
// - User errors flash half hertz for set time
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`include "gsdl_defines.svh"
`default_nettype none
module gsdl_top #(
   parameter int P_DIP_NODE_W = 6,
   parameter int P_DIP_RATE_W = 3,
   parameter int P_FLASH_HALF_CYC = `GSDL_FLASH_HALF_MS * (`GSDL_CLK_HZ / 1000),
   parameter int P_USER_HALF_CYC = `GSDL_USER_HALF_MS * (`GSDL_CLK_HZ / 1000),
   parameter int P_WARN_SEC = `GSDL_WARN_TIME_S
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Avalon-MM slave
   input wire logic [5:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Operator switches (asynchronous pins)
   input wire logic [3:0] i_id_high_selector,
   input wire logic [3:0] i_id_low_selector,
   input wire logic [P_DIP_NODE_W-1:0] i_dip_node,
   input wire logic [P_DIP_RATE_W-1:0] i_dip_rate,
   // Lamps and results
   output gsdl_pkg::gsdl_lamp_t o_pwr_lamp,
   output gsdl_pkg::gsdl_lamp_t o_state_lamp,
   output logic [3:0] o_err_lamps,
   output logic [7:0] o_node_identity,
   output logic [P_DIP_RATE_W-1:0] o_bit_rate,
   output logic o_irq
);
   import gsdl_pkg::*;

   // ==========================================
   // Elaboration checks
   generate
      if (P_DIP_NODE_W < 1 || P_DIP_NODE_W > 7) begin : g_bad_node
         $error("gsdl_top: DIP node width must be 1..7");
      end
      if (P_DIP_RATE_W < 1 || P_DIP_RATE_W > 8) begin : g_bad_rate
         $error("gsdl_top: DIP rate width must be 1..8");
      end
      if (P_WARN_SEC < 1 || P_WARN_SEC > 255) begin : g_bad_warn
         $error("gsdl_top: warning time must be 1..255 seconds");
      end
   endgenerate

   // ==========================================
   // Reset release
   logic rst_meta_r; // First reset stage
   logic rst_n; // Synchronised reset

   // Assert at once, release after two edges
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   // ==========================================
   // Pin synchronisers
   localparam int SW_W = 8 + P_DIP_NODE_W + P_DIP_RATE_W;
   logic [SW_W-1:0] sw_meta_r; // First stage, read only by second
   logic [SW_W-1:0] sw_sync_r; // Safe copy of all switch pins

   // Two flops before anything looks at a switch
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         sw_meta_r <= '0;
         sw_sync_r <= '0;
      end else begin
         sw_meta_r <= {i_id_high_selector, i_id_low_selector, i_dip_node, i_dip_rate};
         sw_sync_r <= sw_meta_r;
      end
   end

   gsdl_sel_t sel_live; // Selector as seen now
   logic [P_DIP_NODE_W-1:0] dip_node_live;
   logic [P_DIP_RATE_W-1:0] dip_rate_live;
   assign {sel_live, dip_node_live, dip_rate_live} = sw_sync_r;

   // ==========================================
   // Flash timebases
   logic fast_ph; // 200 ms half period
   logic slow_ph; // One second half period, half hertz
   logic sec_tick; // Pulse once a second

   gsdl_blink #(.P_HALF_CYC(P_FLASH_HALF_CYC)) u_fast (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .o_phase(fast_ph),
      .o_tick()
   );

   gsdl_blink #(.P_HALF_CYC(P_USER_HALF_CYC)) u_slow (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .o_phase(slow_ph),
      .o_tick(sec_tick)
   );

   // ==========================================
   // Bus handshake
   logic wait_r; // Waitrequest, drops one cycle per access
   logic wr_go; // Write takes effect this edge
   logic rd_go; // Read completes this edge
   logic [31:0] rd_mux; // Read data selected now

   assign wr_go = i_avs_write & ~wait_r;
   assign rd_go = i_avs_read & ~wait_r;

   // Drop waitrequest for exactly one edge per request
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_r <= 1'b1;
      end else if ((i_avs_read | i_avs_write) && wait_r) begin
         wait_r <= 1'b0;
      end else begin
         wait_r <= 1'b1;
      end
   end

   // Byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] res;
      for (int i = 0; i < 4; i++) begin
         res[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
      end
      return res;
   endfunction : merge

   logic [31:0] wdata; // Write data with lanes applied over zero
   assign wdata = merge(32'h0, i_avs_writedata, i_avs_byteenable);

   // ==========================================
   // Software registers
   logic [7:0] nvid_r; // Stored node identity
   logic [7:0] wtime_r; // User error display time, seconds
   logic [31:0] script_r; // Script lamp overrides
   logic [1:0] link_r; // Base halted, PC link active
   logic [`GSDL_IRQ_W-1:0] imask_r; // Interrupt mask
   logic cmd_done; // Script command finished

   assign cmd_done = wr_go && i_avs_address == `GSDL_A_CMD && wdata[`GSDL_CMD_DONE];

   // Plain read/write registers
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         nvid_r <= `GSDL_NVID_RST;
         wtime_r <= `GSDL_WTIME_RST;
         script_r <= 32'h0;
         link_r <= 2'h0;
         imask_r <= '0;
      end else if (wr_go) begin
         case (i_avs_address)
            `GSDL_A_NVID: nvid_r <= i_avs_byteenable[0] ? i_avs_writedata[7:0] : nvid_r;
            `GSDL_A_WTIME: wtime_r <= i_avs_byteenable[0] ? i_avs_writedata[7:0] : wtime_r;
            `GSDL_A_SCRIPT: script_r <= merge(script_r, i_avs_writedata, i_avs_byteenable);
            `GSDL_A_LINK: link_r <= i_avs_byteenable[0] ? i_avs_writedata[1:0] : link_r;
            `GSDL_A_IMASK: imask_r <= wdata[`GSDL_IRQ_W-1:0];
            default: begin
               // Read-only or unmapped: ignored
            end
         endcase
      end
   end

   // ==========================================
   // Selector sampling and mode
   logic [3:0] settle_r; // Cycles after reset before first sample
   logic boot_samp; // Power-up sample strobe
   logic samp; // Any sample strobe
   gsdl_sel_t sel_r; // Held selector byte
   gsdl_mode_t mode_r; // Operating mode
   gsdl_mode_t mode_nxt;

   assign boot_samp = settle_r == `GSDL_SETTLE_CYC - 4'h1;
   assign samp = boot_samp | cmd_done;

   // Wait for the synchronisers to fill before the first sample
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_r <= 4'h0;
      end else if (settle_r != `GSDL_SETTLE_CYC) begin
         settle_r <= settle_r + 4'h1;
      end
   end

   // Next mode from a fresh sample
   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         GSDL_TEST, GSDL_CONFIG: mode_nxt = mode_r;
         GSDL_NORMAL, GSDL_UPDATE: begin
            if (samp) begin
               case (sel_live)
                  `GSDL_CODE_TEST: mode_nxt = GSDL_TEST;
                  `GSDL_CODE_CONFIG: mode_nxt = GSDL_CONFIG;
                  `GSDL_CODE_UPDATE: mode_nxt = GSDL_UPDATE;
                  default: mode_nxt = GSDL_NORMAL;
               endcase
            end
         end
         default: mode_nxt = GSDL_NORMAL;
      endcase
   end

   // Hold the sampled byte and mode
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_r <= '0;
         mode_r <= GSDL_NORMAL;
      end else begin
         mode_r <= mode_nxt;
         if (samp) begin
            sel_r <= sel_live;
         end
      end
   end

   // ==========================================
   // DIP capture and node identity
   logic [P_DIP_NODE_W-1:0] dip_node_r;
   logic [P_DIP_RATE_W-1:0] dip_rate_r;

   // Latch once; later switch moves are ignored until reset
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         dip_node_r <= '0;
         dip_rate_r <= '0;
      end else if (boot_samp) begin
         dip_node_r <= dip_node_live;
         dip_rate_r <= dip_rate_live;
      end
   end

   // Zero on the DIP hands over to the stored value
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_node_identity <= 8'h0;
         o_bit_rate <= '0;
      end else begin
         o_node_identity <= (dip_node_r == '0) ? nvid_r : 8'(dip_node_r);
         o_bit_rate <= dip_rate_r;
      end
   end

   // ==========================================
   // Error hold and expiry
   logic [3:0] err_num_r; // Active error number, zero for none
   logic err_user_r; // Error is user defined
   logic [7:0] err_sec_r; // Seconds since error raised
   logic err_set; // Software raises an error
   logic err_expire; // Display time over
   logic [7:0] err_limit;

   assign err_set = wr_go && i_avs_address == `GSDL_A_ERR && i_avs_byteenable[0];
   assign err_limit = err_user_r ? wtime_r : 8'(P_WARN_SEC);
   // Non-user errors 1..5 never expire; only a reset or a write removes them
   assign err_expire = err_num_r != 4'h0 && (err_user_r || err_num_r >= `GSDL_ERR_WARN_MIN)
      && sec_tick && err_sec_r + 8'h1 >= err_limit;

   // A new error restarts its display time
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         err_num_r <= 4'h0;
         err_user_r <= 1'b0;
         err_sec_r <= 8'h0;
      end else if (err_set) begin
         err_num_r <= i_avs_writedata[3:0];
         err_user_r <= i_avs_writedata[`GSDL_ERR_USER];
         err_sec_r <= 8'h0;
      end else if (err_expire) begin
         err_num_r <= 4'h0;
         err_user_r <= 1'b0;
         err_sec_r <= 8'h0;
      end else if (sec_tick && err_num_r != 4'h0) begin
         err_sec_r <= err_sec_r + 8'h1;
      end
   end

   // ==========================================
   // Interrupts
   logic [`GSDL_IRQ_W-1:0] istat_r; // Sticky event bits
   logic [`GSDL_IRQ_W-1:0] ev; // Events this cycle
   logic [`GSDL_IRQ_W-1:0] rd_snap_r; // Status bits shown to the pending read

   always_comb begin
      ev = '0;
      ev[`GSDL_IRQ_MODE] = mode_nxt != mode_r;
      ev[`GSDL_IRQ_ERR] = err_set && i_avs_writedata[3:0] != 4'h0;
      ev[`GSDL_IRQ_EXPIRE] = err_expire;
      ev[`GSDL_IRQ_SEL] = samp && sel_live != sel_r;
   end

   // Read clears only what was reported, so a new event survives
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         istat_r <= '0;
      end else if (rd_go && i_avs_address == `GSDL_A_ISTAT) begin
         istat_r <= (istat_r & ~rd_snap_r) | ev;
      end else begin
         istat_r <= istat_r | ev;
      end
   end

   // Level interrupt while an unmasked bit is set
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(istat_r & imask_r);
      end
   end

   // ==========================================
   // Read data
   always_comb begin
      case (i_avs_address)
         `GSDL_A_SEL: rd_mux = {22'h0, mode_r, sel_r};
         `GSDL_A_NODE: rd_mux = {16'h0, 8'(dip_rate_r), o_node_identity};
         `GSDL_A_NVID: rd_mux = {24'h0, nvid_r};
         `GSDL_A_ERR: rd_mux = {27'h0, err_user_r, err_num_r};
         `GSDL_A_WTIME: rd_mux = {24'h0, wtime_r};
         `GSDL_A_SCRIPT: rd_mux = script_r;
         `GSDL_A_LINK: rd_mux = {30'h0, link_r};
         `GSDL_A_ISTAT: rd_mux = 32'(istat_r);
         `GSDL_A_IMASK: rd_mux = 32'(imask_r);
         default: rd_mux = 32'h0;
      endcase
   end

   // Capture at the request edge so data stand when waitrequest drops
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_avs_readdata <= 32'h0;
         rd_snap_r <= '0;
      end else if (i_avs_read && wait_r) begin
         o_avs_readdata <= rd_mux;
         rd_snap_r <= istat_r;
      end
   end

   assign o_avs_waitrequest = wait_r;

   // ==========================================
   // Lamp drive
   gsdl_script_st_t sc_st; // Scripted state lamp choice
   logic sc_st_en; // Script owns state lamp
   logic sc_er_en; // Script owns error lamps
   logic err_on; // An error is displayed
   logic err_ph; // Flash phase for the error display

   assign sc_st = gsdl_script_st_t'(script_r[`GSDL_SCR_ST_LSB +: 3]);
   assign sc_st_en = script_r[`GSDL_SCR_ST_EN];
   assign sc_er_en = script_r[`GSDL_SCR_ER_EN];
   assign err_on = err_num_r != 4'h0;
   assign err_ph = err_user_r ? slow_ph : fast_ph;

   // Power lamp, halted base with PC link first
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_pwr_lamp <= '0;
      end else if (link_r[`GSDL_LINK_HALT] && link_r[`GSDL_LINK_PC]) begin
         o_pwr_lamp <= '{red: 1'b1, green: 1'b0};
      end else if (mode_r == GSDL_TEST) begin
         o_pwr_lamp <= '{red: fast_ph, green: ~fast_ph};
      end else if (mode_r == GSDL_CONFIG || err_on) begin
         o_pwr_lamp <= '{red: fast_ph, green: 1'b0};
      end else begin
         o_pwr_lamp <= '{red: 1'b0, green: 1'b1};
      end
   end

   // State lamp, script override wins
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_state_lamp <= '0;
      end else if (sc_st_en) begin
         case (sc_st)
            GSDL_SC_GREEN: o_state_lamp <= '{red: 1'b0, green: 1'b1};
            GSDL_SC_GREEN_FL: o_state_lamp <= '{red: 1'b0, green: fast_ph};
            GSDL_SC_GR_FL: o_state_lamp <= '{red: ~fast_ph, green: fast_ph};
            GSDL_SC_RED: o_state_lamp <= '{red: 1'b1, green: 1'b0};
            GSDL_SC_RED_FL: o_state_lamp <= '{red: fast_ph, green: 1'b0};
            default: o_state_lamp <= '0;
         endcase
      end else if (err_on && err_user_r) begin
         o_state_lamp <= '{red: slow_ph, green: 1'b0};
      end else if (err_on) begin
         o_state_lamp <= '{red: 1'b1, green: 1'b0};
      end else if (mode_r == GSDL_TEST || mode_r == GSDL_CONFIG) begin
         o_state_lamp <= '{red: fast_ph, green: 1'b0};
      end else begin
         o_state_lamp <= '0;
      end
   end

   // Error number lamps: weights 1, 2, 4, 8 on bits 0..3
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_err_lamps <= 4'h0;
      end else if (sc_er_en) begin
         o_err_lamps <= script_r[`GSDL_SCR_ER_LSB +: 4];
      end else if (err_on && err_ph) begin
         o_err_lamps <= err_num_r;
      end else begin
         o_err_lamps <= 4'h0;
      end
   end
endmodule : gsdl_top
`default_nettype wire

// ---- testbench/gsdl_top_assertions.sv ----
// Port-level checks for the switch decode and lamp block
`default_nettype none
module gsdl_chk import gsdl_pkg::*; #(
   parameter int P_DIP_NODE_W = 6,
   parameter int P_DIP_RATE_W = 3
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic o_avs_waitrequest,
   input wire logic [P_DIP_NODE_W-1:0] i_dip_node,
   input wire logic [P_DIP_RATE_W-1:0] i_dip_rate,
   input wire gsdl_pkg::gsdl_lamp_t o_pwr_lamp,
   input wire logic [7:0] o_node_identity,
   input wire logic [P_DIP_RATE_W-1:0] o_bit_rate
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================
   // Helper counters
   logic [4:0] boot_r; // Edges since release, saturating
   logic [2:0] quiet_r; // Edges since last write, saturating

   // Boot age; the switch capture lands well before 16
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         boot_r <= 5'h00;
      end else if (boot_r != 5'h1f) begin
         boot_r <= boot_r + 5'h01;
      end
   end
   // Quiet time; software writes may legally move lamps and identity
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         quiet_r <= 3'h0;
      end else if (i_avs_write) begin
         quiet_r <= 3'h0;
      end else if (quiet_r != 3'h7) begin
         quiet_r <= quiet_r + 3'h1;
      end
   end
   // ==========================================
   // Assertions
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   wait_one_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("request not answered in one wait");
   wait_drop_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low too long");
   boot_store_a: assert property (boot_r == 5'h10 && i_dip_node == '0 |-> o_node_identity == 8'h01)
      else $error("stored identity not one after boot");
   boot_dip_a: assert property (boot_r == 5'h10 && i_dip_node != '0 |->
      o_node_identity == 8'(i_dip_node) && o_bit_rate == i_dip_rate)
      else $error("identity or rate not from dip field");
   rate_hold_a: assert property (boot_r == 5'h1f |-> $stable(o_bit_rate))
      else $error("bit rate moved after boot");
   node_hold_a: assert property (boot_r == 5'h1f && quiet_r == 3'h7 |=> $stable(o_node_identity))
      else $error("identity moved without a write");
   pwr_mix_a: assert property (o_pwr_lamp != 2'b11)
      else $error("power lamp lit in both colours");
   alt_period_a: assert property (quiet_r == 3'h7 && $rose(o_pwr_lamp.red) && $fell(o_pwr_lamp.green) |->
      (o_pwr_lamp == 2'b10) [*4] ##1 o_pwr_lamp == 2'b01)
      else $error("test alternation period wrong");
endmodule : gsdl_chk

bind gsdl_top gsdl_chk #(.P_DIP_NODE_W(P_DIP_NODE_W), .P_DIP_RATE_W(P_DIP_RATE_W)) chk_u (
   .i_clk(i_clk), .i_reset_n(i_reset_n), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .o_avs_waitrequest(o_avs_waitrequest), .i_dip_node(i_dip_node), .i_dip_rate(i_dip_rate),
   .o_pwr_lamp(o_pwr_lamp), .o_node_identity(o_node_identity), .o_bit_rate(o_bit_rate));
`default_nettype wire

// ---- testbench/gsdl_panel.sv ----
// Operator panel model: rotary selectors and dip field
`default_nettype none
module gsdl_panel import gsdl_pkg::*; (
   input wire gsdl_pkg::gsdl_sel_t i_sel,
   input wire logic [5:0] i_node,
   input wire logic [2:0] i_rate,
   output logic [3:0] o_id_high_selector,
   output logic [3:0] o_id_low_selector,
   output logic [5:0] o_dip_node,
   output logic [2:0] o_dip_rate
);
   timeunit 1ns;
   timeprecision 100ps;
   // Static contacts; the operator dials DD only for an update
   always_comb begin
      o_id_high_selector = i_sel.hi;
      o_id_low_selector = i_sel.lo;
      o_dip_node = i_node;
      o_dip_rate = i_rate;
   end
endmodule : gsdl_panel
`default_nettype wire

// ---- testbench/gsdl_top_tb.sv ----
// Self-checking bench for the switch decode and lamp block
`include "gsdl_defines.svh"
`default_nettype none
module gsdl_top_tb import gsdl_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================
   // Signals
   logic clk = 1'b0; // Bench clock
   logic rst_n = 1'b0; // Raw reset, active low
   logic avs_rd = 1'b0, avs_wr = 1'b0; // Bus strobes
   logic [5:0] addr = 6'h00;
   logic [31:0] wdata = 32'h0, rdata, q;
   logic wait_rq, irq;
   gsdl_sel_t sel_set = 8'hee; // Operator settings
   logic [5:0] node_set = 6'h00, dipn;
   logic [2:0] rate_set = 3'h5, dipr, rate;
   logic [3:0] hi, lo, err;
   gsdl_lamp_t pwr, st;
   logic [7:0] node;
   int num_errors = 0, checked = 0, c_s, c_e, c_z, c_pr, c_pg;

   always #5 clk = ~clk;
   gsdl_panel pnl_u (.i_sel(sel_set), .i_node(node_set), .i_rate(rate_set), .o_id_high_selector(hi),
      .o_id_low_selector(lo), .o_dip_node(dipn), .o_dip_rate(dipr));
   // Short flash and tick counts keep the run brief
   gsdl_top #(.P_FLASH_HALF_CYC(4), .P_USER_HALF_CYC(8), .P_WARN_SEC(5)) dut_u (.i_clk(clk),
      .i_reset_n(rst_n), .i_avs_address(addr), .i_avs_read(avs_rd), .i_avs_write(avs_wr),
      .i_avs_writedata(wdata), .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq),
      .i_id_high_selector(hi), .i_id_low_selector(lo), .i_dip_node(dipn), .i_dip_rate(dipr),
      .o_pwr_lamp(pwr), .o_state_lamp(st), .o_err_lamps(err), .o_node_identity(node), .o_bit_rate(rate),
      .o_irq(irq));

   // ==========================================
   // Tasks
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // One transfer; held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
      int n = 0;
      avs_rd <= !w;
      avs_wr <= w;
      addr <= a;
      wdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wait_rq !== 1'b0 && n < 50);
      r = rdata;
      if (n >= 50) num_errors++;
      avs_rd <= 1'b0;
      avs_wr <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string nm);
      bus(1'b0, a, 32'h0, q);
      check(nm, q, exp);
   endtask : rd

   // Count lamp patterns over n cycles
   task automatic watch(input gsdl_lamp_t es, input logic [3:0] ee, input int n);
      {c_s, c_e, c_z, c_pr, c_pg} = '0;
      repeat (3) @(posedge clk);
      repeat (n) begin
         @(posedge clk);
         c_s += (st === es);
         c_e += (err === ee);
         c_z += (err === 4'h0);
         c_pr += (pwr === 2'b10);
         c_pg += (pwr === 2'b01);
      end
   endtask : watch

   // Switches set before release so the boot sample sees them
   task automatic boot(input logic [7:0] s, input logic [5:0] n, input logic [2:0] r);
      rst_n <= 1'b0;
      sel_set <= s;
      node_set <= n;
      rate_set <= r;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (20) @(posedge clk);
   endtask : boot

   task automatic test_done();
      $display("Checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done

   // ==========================================
   // Watchdog, about ten times the expected run length
   initial begin
      repeat (4000) @(posedge clk);
      num_errors++;
      test_done();
   end

   // ==========================================
   // Scenarios
   initial begin
      boot(8'hee, 6'h00, 3'h5);
      rd(`GSDL_A_SEL, 32'h3ee, "sel test");
      rd(`GSDL_A_NODE, 32'h0501, "node stored");
      rd(`GSDL_A_NVID, 32'h1, "nvid reset");
      wr(`GSDL_A_NVID, 32'h50);
      rd(`GSDL_A_NODE, 32'h0550, "node big");
      watch(2'b10, 4'h0, 16);
      check("pwr alt", c_pr > 0 && c_pg > 0, 1);
      check("state flash", c_s inside {[1:15]}, 1);
      sel_set <= 8'hff;
      node_set <= 6'h07;
      repeat (4) @(posedge clk);
      wr(`GSDL_A_CMD, 32'h1);
      rd(`GSDL_A_SEL, 32'h3ff, "sel resample");
      rd(`GSDL_A_NODE, 32'h0550, "node held");
      boot(8'hdd, 6'h09, 3'h2);
      rd(`GSDL_A_SEL, 32'h1dd, "sel update");
      rd(`GSDL_A_NODE, 32'h0209, "node dip");
      wr(`GSDL_A_LINK, 32'h3);
      watch(2'b00, 4'h0, 8);
      check("pwr bright", c_pr, 8);
      wr(`GSDL_A_LINK, 32'h0);
      sel_set <= 8'h12;
      repeat (4) @(posedge clk);
      wr(`GSDL_A_CMD, 32'h1);
      rd(`GSDL_A_SEL, 32'h012, "sel normal");
      rd(6'h3c, 32'h0, "unmapped");
      bus(1'b0, `GSDL_A_ISTAT, 32'h0, q);
      wr(`GSDL_A_IMASK, 32'h2);
      wr(`GSDL_A_ERR, 32'h7);
      repeat (2) @(posedge clk);
      check("irq", irq, 1);
      rd(`GSDL_A_ISTAT, 32'h2, "istat err");
      @(posedge clk);
      check("irq clear", irq, 0);
      watch(2'b10, 4'h7, 8);
      check("state red", c_s, 8);
      check("err number", c_e > 0 && c_z > 0 && c_e + c_z == 8, 1);
      repeat (40) @(posedge clk);
      watch(2'b00, 4'h0, 8);
      check("warn cleared", c_s + c_z, 16);
      rd(`GSDL_A_ISTAT, 32'h4, "istat expire");
      wr(`GSDL_A_SCRIPT, 32'h153);
      watch(2'b01, 4'ha, 8);
      check("script lamps", c_s + c_e, 16);
      wr(`GSDL_A_SCRIPT, 32'h0);
      wr(`GSDL_A_WTIME, 32'h8);
      wr(`GSDL_A_ERR, 32'h13);
      watch(2'b10, 4'h3, 16);
      check("user flash", c_s inside {[1:15]} && c_e > 0 && c_z > 0, 1);
      repeat (80) @(posedge clk);
      watch(2'b00, 4'h0, 8);
      check("user cleared", c_z, 8);
      test_done();
   end
endmodule : gsdl_top_tb
`default_nettype wire
